// *** logic/dmct_pkg.sv ***
// Constants shared by the dual mode capture timer.
// Assumes a Wishbone slave decode of register indices on word addresses.
package dmct_pkg;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [15:0] DMCT_IDX_LOW_RELOAD = 16'h7F14;
	localparam logic [15:0] DMCT_IDX_HIGH_RELOAD = 16'h7F15;
	localparam logic [15:0] DMCT_IDX_TIMER_CONTROL = 16'h7F16;
	localparam logic [15:0] DMCT_IDX_PRESCALE_MODE = 16'h7F17;
	localparam logic [15:0] DMCT_IDX_LOW_COUNT = 16'h7F18;
	localparam logic [15:0] DMCT_IDX_HIGH_COUNT = 16'h7F19;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DMCT_CTL_HIGH_RUN = 7;
	localparam int DMCT_CTL_HIGH_FLAG = 6;
	localparam int DMCT_CTL_HIGH_INT_EN = 5;
	localparam int DMCT_CTL_CLK_SEL_HI = 4;
	localparam int DMCT_CTL_CLK_SEL_LO = 3;
	localparam int DMCT_CTL_RUN = 2;
	localparam int DMCT_CTL_LOW_FLAG = 1;
	localparam int DMCT_CTL_LOW_INT_EN = 0;
	localparam int DMCT_PM_READ_SEL = 7;
	localparam int DMCT_PM_LEN8 = 6;
	localparam int DMCT_PM_CAPT_EN = 5;
	localparam int DMCT_PM_PRESCALE_HI = 4;
	localparam int DMCT_PM_PRESCALE_LO = 0;

	// ****************************************
	// Reset values and the byte maximum
	// ****************************************
	localparam logic [7:0] DMCT_RST_BYTE = 8'h00;
	localparam logic [4:0] DMCT_RST_PRESCALE = 5'h00;
	localparam logic [7:0] DMCT_BYTE_MAX = 8'hFF;

	// ****************************************
	// Count clock selection
	// ****************************************
	typedef enum logic [1:0] {
		DMCT_CLK_SYS = 2'b00,
		DMCT_CLK_RC = 2'b01,
		DMCT_CLK_FIRST_OSC = 2'b10,
		DMCT_CLK_SECOND_OSC = 2'b11
	} dmct_clk_sel_type;
endpackage

// *** logic/dmct_timer.sv ***
// Dual mode capture timer: 5-bit prescaler, 16-bit or 2 x 8-bit timer, capture.
// Assumes a classic Wishbone master on clk_sys and oscillator inputs
// already synchronous to clk_sys.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps

module dmct_timer
	import dmct_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [ADDR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic rc_osc,
	input wire logic first_oscillator_input,
	input wire logic second_oscillator_input,
	output logic irq_low,
	output logic irq_high,
	output logic irq_timer
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic rose(input logic now_v, input logic old_v);
		rose = now_v & ~old_v;
	endfunction

	function automatic logic [31:0] byte_word(input logic [7:0] byte_v);
		byte_word = {24'h00_0000, byte_v};
	endfunction

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] low_reload_q;
	logic [7:0] high_reload_q;
	logic [7:0] ctl_q;
	logic [7:0] ctl_d;
	logic [7:0] pm_q;
	logic [7:0] low_buf_q;
	logic [7:0] high_buf_q;
	logic [7:0] low_cnt_q;
	logic [7:0] high_cnt_q;
	logic [7:0] low_cap_q;
	logic [7:0] high_cap_q;
	logic [4:0] pre_q;
	logic rc_q;
	logic first_osc_q;
	logic second_osc_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic irq_low_q;
	logic irq_high_q;

	logic run;
	logic high_run_bit;
	logic len8;
	logic capt_en;
	logic read_sel;
	logic [4:0] prescale_val;
	dmct_clk_sel_type clk_sel;
	logic tick;
	logic pre_match;
	logic low_match;
	logic low_ovf;
	logic high_match;
	logic high_run;
	logic low_flag_set;
	logic high_flag_set;
	logic low_flag_rise;
	logic high_flag_rise;
	logic bus_req;
	logic bus_wr;
	logic [15:0] idx;
	logic wr_low_reload;
	logic wr_high_reload;
	logic wr_prescale_mode;
	logic wr_timer_control;

	assign run = ctl_q[DMCT_CTL_RUN];
	assign high_run_bit = ctl_q[DMCT_CTL_HIGH_RUN];
	assign len8 = pm_q[DMCT_PM_LEN8];
	assign capt_en = pm_q[DMCT_PM_CAPT_EN];
	assign read_sel = pm_q[DMCT_PM_READ_SEL];
	assign prescale_val = pm_q[DMCT_PM_PRESCALE_HI:DMCT_PM_PRESCALE_LO];
	assign clk_sel = dmct_clk_sel_type'(ctl_q[DMCT_CTL_CLK_SEL_HI:DMCT_CTL_CLK_SEL_LO]);

	// ****************************************
	// Count clock selection
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rc_q <= 1'b0;
		end else begin
			rc_q <= rc_osc;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			first_osc_q <= 1'b0;
		end else begin
			first_osc_q <= first_oscillator_input;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			second_osc_q <= 1'b0;
		end else begin
			second_osc_q <= second_oscillator_input;
		end
	end

	always_comb begin
		case (clk_sel)
			DMCT_CLK_SYS: tick = 1'b1;
			DMCT_CLK_RC: tick = rose(rc_osc, rc_q);
			DMCT_CLK_FIRST_OSC: tick = rose(first_oscillator_input, first_osc_q);
			DMCT_CLK_SECOND_OSC: tick = rose(second_oscillator_input, second_osc_q);
			default: tick = 1'b0;
		endcase
	end

	// ****************************************
	// Prescaler
	// ****************************************
	assign pre_match = run & tick & (pre_q == prescale_val);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pre_q <= DMCT_RST_PRESCALE;
		end else if (!run) begin
			pre_q <= DMCT_RST_PRESCALE;
		end else if (pre_match) begin
			pre_q <= DMCT_RST_PRESCALE;
		end else if (tick) begin
			pre_q <= pre_q + 5'h01;
		end
	end

	// ****************************************
	// Match detection
	// ****************************************
	assign high_run = len8 ? high_run_bit : run;
	assign low_ovf = pre_match & (low_cnt_q == DMCT_BYTE_MAX);
	always_comb begin
		if (len8) begin
			low_match = pre_match & (low_cnt_q == low_buf_q);
			high_match = high_run & (high_cnt_q == high_buf_q);
		end else begin
			low_match = pre_match & ({high_cnt_q, low_cnt_q} == {high_buf_q, low_buf_q});
			high_match = low_match;
		end
	end

	// ****************************************
	// Counters
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt_q <= DMCT_RST_BYTE;
		end else if (!run) begin
			low_cnt_q <= DMCT_RST_BYTE;
		end else if (low_match) begin
			low_cnt_q <= DMCT_RST_BYTE;
		end else if (pre_match) begin
			low_cnt_q <= low_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			high_cnt_q <= DMCT_RST_BYTE;
		end else if (!high_run) begin
			high_cnt_q <= DMCT_RST_BYTE;
		end else if (high_match) begin
			high_cnt_q <= DMCT_RST_BYTE;
		end else if (len8 || low_ovf) begin
			high_cnt_q <= high_cnt_q + 8'h01;
		end
	end

	// ****************************************
	// Match buffers
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_buf_q <= DMCT_RST_BYTE;
		end else if (!run || low_match) begin
			low_buf_q <= low_reload_q;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			high_buf_q <= DMCT_RST_BYTE;
		end else if (!high_run || high_match) begin
			high_buf_q <= high_reload_q;
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign bus_req = wb_cyc & wb_stb & ~ack_q;
	assign bus_wr = bus_req & wb_we & wb_sel[0];
	assign idx = 16'(wb_adr[ADDR_W-1:2]);

	always_comb begin
		wr_low_reload = 1'b0;
		wr_high_reload = 1'b0;
		wr_prescale_mode = 1'b0;
		wr_timer_control = 1'b0;
		if (idx == DMCT_IDX_LOW_RELOAD) begin
			wr_low_reload = bus_wr;
		end else if (idx == DMCT_IDX_HIGH_RELOAD) begin
			wr_high_reload = bus_wr;
		end else if (idx == DMCT_IDX_TIMER_CONTROL) begin
			wr_timer_control = bus_wr;
		end else if (idx == DMCT_IDX_PRESCALE_MODE) begin
			wr_prescale_mode = bus_wr;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_reload_q <= DMCT_RST_BYTE;
		end else if (wr_low_reload) begin
			low_reload_q <= wb_dat_w[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			high_reload_q <= DMCT_RST_BYTE;
		end else if (wr_high_reload) begin
			high_reload_q <= wb_dat_w[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pm_q <= DMCT_RST_BYTE;
		end else if (wr_prescale_mode) begin
			pm_q <= wb_dat_w[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dat_q <= 32'h0000_0000;
		end else if (bus_req && !wb_we) begin
			if (idx == DMCT_IDX_LOW_RELOAD) begin
				dat_q <= byte_word(read_sel ? low_cap_q : low_reload_q);
			end else if (idx == DMCT_IDX_HIGH_RELOAD) begin
				dat_q <= byte_word(read_sel ? high_cap_q : high_reload_q);
			end else if (idx == DMCT_IDX_TIMER_CONTROL) begin
				dat_q <= byte_word(ctl_q);
			end else if (idx == DMCT_IDX_PRESCALE_MODE) begin
				dat_q <= byte_word(pm_q);
			end else if (idx == DMCT_IDX_LOW_COUNT) begin
				dat_q <= byte_word(low_cnt_q);
			end else if (idx == DMCT_IDX_HIGH_COUNT) begin
				dat_q <= byte_word(high_cnt_q);
			end else begin
				dat_q <= 32'h0000_0000;
			end
		end
	end

	assign wb_ack = ack_q;
	assign wb_dat_r = dat_q;

	// ****************************************
	// Control register and flags
	// ****************************************
	assign low_flag_set = low_match;
	assign high_flag_set = len8 & high_match;

	always_comb begin
		ctl_d = ctl_q;
		if (wr_timer_control) begin
			ctl_d = wb_dat_w[7:0];
		end
		if (low_flag_set) begin
			ctl_d[DMCT_CTL_LOW_FLAG] = 1'b1;
		end
		if (high_flag_set) begin
			ctl_d[DMCT_CTL_HIGH_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_q <= DMCT_RST_BYTE;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	assign low_flag_rise = rose(ctl_d[DMCT_CTL_LOW_FLAG], ctl_q[DMCT_CTL_LOW_FLAG]);
	assign high_flag_rise = rose(ctl_d[DMCT_CTL_HIGH_FLAG], ctl_q[DMCT_CTL_HIGH_FLAG]);

	// ****************************************
	// Capture registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_cap_q <= DMCT_RST_BYTE;
		end else if (capt_en && high_flag_rise) begin
			low_cap_q <= low_cnt_q;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			high_cap_q <= DMCT_RST_BYTE;
		end else if (capt_en && (len8 ? low_flag_rise : high_flag_rise)) begin
			high_cap_q <= high_cnt_q;
		end
	end

	// ****************************************
	// Interrupt requests
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_low_q <= 1'b0;
			irq_high_q <= 1'b0;
		end else begin
			irq_low_q <= ctl_q[DMCT_CTL_LOW_FLAG] & ctl_q[DMCT_CTL_LOW_INT_EN];
			irq_high_q <= ctl_q[DMCT_CTL_HIGH_FLAG] & ctl_q[DMCT_CTL_HIGH_INT_EN];
		end
	end

	assign irq_low = irq_low_q;
	assign irq_high = irq_high_q;
	assign irq_timer = irq_low_q | irq_high_q;

endmodule

// *** tb/dmct_timer_asserts.sv ***
// Port checker for the dual mode capture timer.
// Assumes it is bound onto dmct_timer, driven by a classic Wishbone master.
`timescale 1ns/1ps
module dmct_timer_asserts
	import dmct_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [ADDR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire logic rc_osc,
	input wire logic first_oscillator_input,
	input wire logic second_oscillator_input,
	input wire logic irq_low,
	input wire logic irq_high,
	input wire logic irq_timer
);
	// ****************
	// Shadow of writes
	// ****************
	logic wr_take;
	logic ctw;
	logic [7:0] lr_q;
	logic rs_q;
	logic low_en_q;
	logic high_en_q;
	logic low_clr;
	logic high_clr;
	assign wr_take = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0];
	assign ctw = wr_take && wb_adr[ADDR_W-1:2] == DMCT_IDX_TIMER_CONTROL;
	// Control writes that drop a flag or its enable
	assign low_clr = ctw && !(wb_dat_w[DMCT_CTL_LOW_FLAG] && wb_dat_w[DMCT_CTL_LOW_INT_EN]);
	assign high_clr = ctw && !(wb_dat_w[DMCT_CTL_HIGH_FLAG] && wb_dat_w[DMCT_CTL_HIGH_INT_EN]);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			lr_q <= 8'h00;
			rs_q <= 1'b0;
			low_en_q <= 1'b0;
			high_en_q <= 1'b0;
		end else begin
			if (wr_take && wb_adr[ADDR_W-1:2] == DMCT_IDX_LOW_RELOAD) lr_q <= wb_dat_w[7:0];
			if (wr_take && wb_adr[ADDR_W-1:2] == DMCT_IDX_PRESCALE_MODE) rs_q <= wb_dat_w[7];
			if (ctw) low_en_q <= wb_dat_w[DMCT_CTL_LOW_INT_EN];
			if (ctw) high_en_q <= wb_dat_w[DMCT_CTL_HIGH_INT_EN];
		end
	end
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_take; wb_cyc && wb_stb && !wb_ack; endsequence
	property p_ack_next; s_take |=> wb_ack; endproperty
	property p_ack_once; wb_ack |=> !wb_ack; endproperty
	property p_rst_out; $past(sys_rst) |-> !irq_low && !irq_high && !wb_ack; endproperty
	property p_irq_or; irq_timer == (irq_low || irq_high); endproperty
	property p_rld_read;
		wb_ack && !wb_we && wb_adr[ADDR_W-1:2] == DMCT_IDX_LOW_RELOAD && !rs_q
			|-> wb_dat_r[7:0] == lr_q;
	endproperty
	property p_low_en; irq_low |-> $past(low_en_q); endproperty
	property p_high_en; irq_high |-> $past(high_en_q); endproperty
	property p_low_hold; $fell(irq_low) |-> $past(low_clr, 2); endproperty
	property p_high_hold; $fell(irq_high) |-> $past(high_clr, 2); endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
	a_irq_or: assert property (p_irq_or) else $error("shared request wrong");
	a_rld_read: assert property (p_rld_read) else $error("reload readback wrong");
	a_low_en: assert property (p_low_en) else $error("low request while disabled");
	a_high_en: assert property (p_high_en) else $error("high request while disabled");
	a_low_hold: assert property (p_low_hold) else $error("low request fell alone");
	a_high_hold: assert property (p_high_hold) else $error("high request fell alone");
endmodule

bind dmct_timer dmct_timer_asserts #(.ADDR_W(ADDR_W)) i_dmct_timer_asserts (.clk_sys, .sys_rst,
	.wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .rc_osc,
	.first_oscillator_input, .second_oscillator_input, .irq_low, .irq_high, .irq_timer);

// *** tb/tb_top.sv ***
// Self-checking bench for the dual mode capture timer.
// Assumes dmct_timer with its checker bound; the bench drives every input port.
`timescale 1ns/1ps
module tb_top;
	import dmct_pkg::*;
	// ****************
	// Signals
	// ****************
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [17:0] wb_adr = 18'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r, x;
	logic wb_ack, irq_low, irq_high, irq_timer;
	logic rc_osc = 1'b0, first_oscillator_input = 1'b0, second_oscillator_input = 1'b0;
	logic [7:0] c;
	int n_fail = 0, comparisons = 0, cyc = 0, t0, t1, p, l, h, s;
	int dv[4] = '{1, 2, 4, 6};
	dmct_timer #(.ADDR_W(18)) i_dmct_timer (.clk_sys, .sys_rst, .wb_cyc, .wb_stb, .wb_we,
		.wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .rc_osc, .first_oscillator_input,
		.second_oscillator_input, .irq_low, .irq_high, .irq_timer);
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// Count clocks with periods of 2, 4 and 6 system cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		rc_osc <= ~rc_osc;
		if (cyc % 2 == 1) first_oscillator_input <= ~first_oscillator_input;
		if (cyc % 3 == 2) second_oscillator_input <= ~second_oscillator_input;
	end
	// ****************
	// Tasks
	// ****************
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] d,
		input logic s0, output logic [31:0] r);
		int k;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= {i, 2'h0};
		wb_sel <= {3'h7, s0};
		wb_dat_w <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (wb_ack !== 1'b1 && k < 50);
		r = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin n_fail++; finish_test(); end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic s0 = 1'b1);
		wb(1'b1, i, d, s0, x);
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] e);
		wb(1'b0, i, 8'h00, 1'b1, x);
		chk(x, {24'h0, e});
	endtask
	// Waits for a fresh rising edge of one request line
	task automatic rise(input bit hb, output int t);
		int k;
		logic pv;
		pv = 1'b1;
		for (k = 0; k < 4000; k++) begin
			@(posedge clk_sys);
			if (pv === 1'b0 && (hb ? irq_high : irq_low) === 1'b1) break;
			pv = hb ? irq_high : irq_low;
		end
		t = cyc;
		if (k == 4000) begin n_fail++; finish_test(); end
	endtask
	// Period between two flag sets, clearing the flag in between
	task automatic per(input bit hb, input logic [7:0] cv, input int e);
		rise(hb, t0);
		wr(DMCT_IDX_TIMER_CONTROL, cv);
		rise(hb, t1);
		chk(t1 - t0, e);
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		s = $urandom(32'h5DDA40C6);
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (s = 0; s < 9; s++) rd(DMCT_IDX_LOW_RELOAD + s[15:0], 8'h00);
		for (s = 0; s < 2; s++) begin
			h = $urandom % 256;
			wr(DMCT_IDX_LOW_RELOAD + s[15:0], h[7:0]);
			wr(DMCT_IDX_LOW_RELOAD + s[15:0], ~h[7:0], 1'b0);
			rd(DMCT_IDX_LOW_RELOAD + s[15:0], h[7:0]);
		end
		p = $urandom % 4;
		l = 9 + $urandom % 8;
		wr(DMCT_IDX_PRESCALE_MODE, {3'h2, p[4:0]});
		wr(DMCT_IDX_LOW_RELOAD, l[7:0]);
		for (s = 0; s < 4; s++) begin
			c = {3'h0, s[1:0], 3'h5};
			wr(DMCT_IDX_TIMER_CONTROL, c);
			per(1'b0, c, (l + 1) * (p + 1) * dv[s]);
		end
		h = 7 + $urandom % 24;
		wr(DMCT_IDX_HIGH_RELOAD, h[7:0]);
		wr(DMCT_IDX_TIMER_CONTROL, 8'hA0);
		per(1'b1, 8'hA0, h + 1);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h00);
		wr(DMCT_IDX_PRESCALE_MODE, 8'h00);
		wr(DMCT_IDX_HIGH_RELOAD, 8'h01);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h05);
		per(1'b0, 8'h05, 257 + l);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h00);
		wr(DMCT_IDX_PRESCALE_MODE, 8'h3F);
		wr(DMCT_IDX_LOW_RELOAD, 8'hC8);
		wr(DMCT_IDX_HIGH_RELOAD, 8'h00);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h04);
		t0 = cyc;
		while (cyc - t0 < 112) @(posedge clk_sys);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h44);
		wr(DMCT_IDX_PRESCALE_MODE, 8'hBF);
		rd(DMCT_IDX_LOW_RELOAD, 8'h03);
		rd(DMCT_IDX_HIGH_RELOAD, 8'h00);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h00);
		rd(DMCT_IDX_LOW_COUNT, 8'h00);
		// 8-bit mode: software high flag captures the stopped low counter
		wr(DMCT_IDX_PRESCALE_MODE, 8'hE0);
		wr(DMCT_IDX_TIMER_CONTROL, 8'h40);
		rd(DMCT_IDX_LOW_RELOAD, 8'h00);
		finish_test();
	end
endmodule
